// File: hdl/pwrseq_pkg.sv
// Shared constants, types and UART step functions for the power sequencing link.
package pwrseq_pkg;

  // Clock and timing figures; the gaps are counted in mclk cycles.
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned CLK_PER_MS = CLK_HZ / 1000;
  localparam int unsigned GAP_MS = 2;
  localparam int unsigned CTS_MIN_MS = 100;
  localparam int unsigned CTS_MAX_MS = 500;
  localparam int unsigned EN_LOW_MS = 80;
  localparam int unsigned GAP_CYC = GAP_MS * CLK_PER_MS;
  localparam int unsigned CTS_MIN_CYC = CTS_MIN_MS * CLK_PER_MS;
  localparam int unsigned CTS_MAX_CYC = CTS_MAX_MS * CLK_PER_MS;
  localparam int unsigned EN_LOW_CYC = EN_LOW_MS * CLK_PER_MS;

  // Widths.
  localparam int unsigned CNT_W = 32;
  localparam int unsigned DIV_W = 16;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned STOP_BITS = 1;
  localparam int unsigned STEP_W = 4;
  localparam int unsigned GPO_W = 5;
  localparam int unsigned GPI_W = 3;

  // Service access forces a fixed serial setting of 38400 baud, 8N1.
  localparam int unsigned SERVICE_BAUD = 38400;
  localparam logic [DIV_W-1:0] SERVICE_DIV = DIV_W'(CLK_HZ / SERVICE_BAUD);
  localparam logic [STEP_W-1:0] FRAME_STEPS = STEP_W'(DATA_W + STOP_BITS);

  typedef enum logic [3:0] {
    DEV_OFF   = 4'h1,
    DEV_BOOT  = 4'h2,
    DEV_GPIO  = 4'h4,
    DEV_READY = 4'h8
  } dev_phase_type;

  typedef enum logic [8:0] {
    H_OFF      = 9'h001,
    H_MAIN     = 9'h002,
    H_ENA      = 9'h004,
    H_WAIT_CTS = 9'h008,
    H_RUN      = 9'h010,
    H_FAULT    = 9'h020,
    H_DISABLE  = 9'h040,
    H_PINS_LOW = 9'h080,
    H_IO_OFF   = 9'h100
  } host_phase_type;

  typedef struct packed {
    logic busy;
    logic line;
    logic [DATA_W:0] shift;
    logic [STEP_W-1:0] steps;
    logic [DIV_W-1:0] cnt;
  } uart_tx_type;

  typedef struct packed {
    logic busy;
    logic [DATA_W-1:0] shift;
    logic [STEP_W-1:0] steps;
    logic [DIV_W-1:0] cnt;
    logic done;
    logic err;
    logic [DATA_W-1:0] data;
  } uart_rx_type;

  localparam uart_tx_type TX_RESET = '{busy: 1'h0, line: 1'h1, shift: '1, steps: '0, cnt: '0};
  localparam uart_rx_type RX_RESET = '{busy: 1'h0, shift: '0, steps: '0, cnt: '0, done: 1'h0, err: 1'h0, data: '0};

  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] c);
    return (c == '1) ? c : c + 1'h1;
  endfunction

  // A zero divisor would stall the UART, so it falls back to the service rate.
  function automatic logic [DIV_W-1:0] baud_select(input logic service_on, input logic [DIV_W-1:0] cfg);
    return (service_on || cfg == '0) ? SERVICE_DIV : cfg;
  endfunction

  // Start bit, DATA_W bits LSB first, one stop bit; each held for div cycles.
  function automatic uart_tx_type tx_step(input uart_tx_type s, input logic en, input logic load,
                                          input logic [DATA_W-1:0] data, input logic [DIV_W-1:0] div);
    uart_tx_type n;
    n = s;
    if (!en) begin
      n = TX_RESET;
    end else if (!s.busy) begin
      if (load) begin
        n.busy = 1'h1;
        n.line = 1'h0;
        n.shift = {1'h1, data};
        n.steps = FRAME_STEPS;
        n.cnt = div - 1'h1;
      end
    end else if (s.cnt != '0) begin
      n.cnt = s.cnt - 1'h1;
    end else if (s.steps == '0) begin
      n.busy = 1'h0;
    end else begin
      n.line = s.shift[0];
      n.shift = {1'h1, s.shift[DATA_W:1]};
      n.steps = s.steps - 1'h1;
      n.cnt = div - 1'h1;
    end
    return n;
  endfunction

  // Samples at mid-bit; a start bit that is high at its centre is taken as a glitch.
  function automatic uart_rx_type rx_step(input uart_rx_type s, input logic en, input logic line,
                                          input logic [DIV_W-1:0] div);
    uart_rx_type n;
    n = s;
    n.done = 1'h0;
    n.err = 1'h0;
    if (!en) begin
      n = RX_RESET;
    end else if (!s.busy) begin
      if (!line) begin
        n.busy = 1'h1;
        n.steps = FRAME_STEPS;
        n.cnt = div >> 1;
      end
    end else if (s.cnt != '0) begin
      n.cnt = s.cnt - 1'h1;
    end else begin
      n.cnt = div - 1'h1;
      if (s.steps == FRAME_STEPS) begin
        if (line) begin
          n.busy = 1'h0;
        end else begin
          n.steps = s.steps - 1'h1;
        end
      end else if (s.steps != '0) begin
        n.shift = {line, s.shift[DATA_W-1:1]};
        n.steps = s.steps - 1'h1;
      end else begin
        n.busy = 1'h0;
        n.done = line;
        n.err = ~line;
        if (line) begin
          n.data = s.shift;
        end
      end
    end
    return n;
  endfunction

endpackage

// File: hdl/module_link_if.sv
// Pin-level link between the host controller and the radio module.
`timescale 1ns/10ps
`default_nettype none
interface module_link_if;
  logic vcc_in;
  logic module_enable;
  logic vcc_io;
  logic clear_to_send_out_n;
  logic receive_data_out_n;
  logic request_to_send_in_n_drv;
  logic request_to_send_in_n_oe;
  logic transmit_data_in_n_drv;
  logic transmit_data_in_n_oe;
  logic service_n_drv;
  logic service_n_oe;
  logic [pwrseq_pkg::GPI_W-1:0] gpi_drv;
  logic gpi_oe;
  logic [pwrseq_pkg::GPO_W-1:0] gpo_val;
  logic gpo_oe;

  modport module_side (
    input vcc_in, module_enable, vcc_io,
    input request_to_send_in_n_drv, request_to_send_in_n_oe,
    input transmit_data_in_n_drv, transmit_data_in_n_oe,
    input service_n_drv, service_n_oe, gpi_drv, gpi_oe,
    output clear_to_send_out_n, receive_data_out_n, gpo_val, gpo_oe
  );

  modport host_side (
    output vcc_in, module_enable, vcc_io,
    output request_to_send_in_n_drv, request_to_send_in_n_oe,
    output transmit_data_in_n_drv, transmit_data_in_n_oe,
    output service_n_drv, service_n_oe, gpi_drv, gpi_oe,
    input clear_to_send_out_n, receive_data_out_n, gpo_val, gpo_oe
  );
endinterface
`default_nettype wire

// File: hdl/module_end.sv
// Radio module end: power-up timing of CTS and GPIO, pull-ups, service mode and UART1.
// How it works
// - Host waits over 2 ms, supply to enable.
// - Host waits over 2 ms, enable to IO.
// - CTS ready between 100 and 500 ms.
// - No CTS before IO high 2 ms.
// - No GPIO drive before IO high 2 ms.
// - GPIO active no later than CTS ready.
// - Host lowers input pins 80 ms after disable.
// - Host lowers GPIO before removing IO supply.
// - Host removes IO supply before main supply.
// - CTS output is active low.
// - Host drives RTS low; pulled up otherwise.
// - Transmit data input pulled up, active low.
// - Service input pulled up, active low.
// - Service low forces 38400 baud 8N1.
`timescale 1ns/10ps
`default_nettype none
module module_end #(
  parameter int unsigned GAP_CYC = pwrseq_pkg::GAP_CYC,
  parameter int unsigned CTS_MIN_CYC = pwrseq_pkg::CTS_MIN_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  module_link_if.module_side link,
  input wire logic [pwrseq_pkg::DIV_W-1:0] baud_div,
  input wire logic tx_valid,
  input wire logic [pwrseq_pkg::DATA_W-1:0] tx_data,
  output logic tx_ready,
  output logic rx_valid,
  output logic [pwrseq_pkg::DATA_W-1:0] rx_data,
  output logic rx_frame_error,
  input wire logic [pwrseq_pkg::GPO_W-1:0] gpo_value,
  output logic [pwrseq_pkg::GPI_W-1:0] gpi_value,
  output logic service_mode,
  output logic ready
);

  // Pulled-up lines reset high so no false start bit follows reset.
  typedef struct packed {
    pwrseq_pkg::dev_phase_type phase;
    logic [1:0] main_sync;
    logic [1:0] en_sync;
    logic [1:0] io_sync;
    logic [1:0] rts_sync;
    logic [1:0] txd_sync;
    logic [1:0] svc_sync;
    logic [pwrseq_pkg::GPI_W-1:0] gpi_meta;
    logic [pwrseq_pkg::GPI_W-1:0] gpi_sync;
    logic [pwrseq_pkg::GPI_W-1:0] gpi_value;
    logic [pwrseq_pkg::CNT_W-1:0] en_cnt;
    logic [pwrseq_pkg::CNT_W-1:0] io_cnt;
    logic cts_ready;
    logic gpo_oe;
    logic [pwrseq_pkg::GPO_W-1:0] gpo_val;
    pwrseq_pkg::uart_tx_type tx;
    pwrseq_pkg::uart_rx_type rx;
  } dev_state_type;

  localparam dev_state_type STATE_RESET = '{
    phase: pwrseq_pkg::DEV_OFF,
    main_sync: '0,
    en_sync: '0,
    io_sync: '0,
    rts_sync: '1,
    txd_sync: '1,
    svc_sync: '1,
    gpi_meta: '1,
    gpi_sync: '1,
    gpi_value: '0,
    en_cnt: '0,
    io_cnt: '0,
    cts_ready: 1'h0,
    gpo_oe: 1'h0,
    gpo_val: '0,
    tx: pwrseq_pkg::TX_RESET,
    rx: pwrseq_pkg::RX_RESET
  };

  dev_state_type state_reg;
  dev_state_type state_next;
  logic [pwrseq_pkg::DIV_W-1:0] div;
  logic tx_load;

  // Undriven inputs float to the internal pull-up level before synchronising.
  logic rts_level;
  logic txd_level;
  logic svc_level;
  logic [pwrseq_pkg::GPI_W-1:0] gpi_level;

  assign rts_level = link.request_to_send_in_n_oe ? link.request_to_send_in_n_drv : 1'h1;
  assign txd_level = link.transmit_data_in_n_oe ? link.transmit_data_in_n_drv : 1'h1;
  assign svc_level = link.service_n_oe ? link.service_n_drv : 1'h1;
  assign gpi_level = link.gpi_oe ? link.gpi_drv : '1;

  // Service mode overrides the configured rate only while the pin stays low.
  assign div = pwrseq_pkg::baud_select(~state_reg.svc_sync[1], baud_div);

  // Sending waits for the host's request-to-send, which is active low.
  assign tx_ready = state_reg.cts_ready & ~state_reg.tx.busy & ~state_reg.rts_sync[1];
  assign tx_load = tx_ready & tx_valid;

  always_comb begin
    logic en_on;
    logic io_on;
    logic io_ok;
    en_on = 1'h0;
    io_on = 1'h0;
    io_ok = 1'h0;
    state_next = state_reg;

    state_next.main_sync = {state_reg.main_sync[0], link.vcc_in};
    state_next.en_sync = {state_reg.en_sync[0], link.module_enable};
    state_next.io_sync = {state_reg.io_sync[0], link.vcc_io};
    state_next.rts_sync = {state_reg.rts_sync[0], rts_level};
    state_next.txd_sync = {state_reg.txd_sync[0], txd_level};
    state_next.svc_sync = {state_reg.svc_sync[0], svc_level};

    // The general inputs pass the same two stages.
    state_next.gpi_meta = gpi_level;
    state_next.gpi_sync = state_reg.gpi_meta;

    // The enable only counts while the main supply is also present.
    en_on = state_reg.main_sync[1] & state_reg.en_sync[1];
    io_on = state_reg.io_sync[1];
    io_ok = state_reg.io_cnt > pwrseq_pkg::CNT_W'(GAP_CYC);

    // Counts saturate, so a long run never wraps below a gate.
    state_next.en_cnt = en_on ? pwrseq_pkg::sat_inc(state_reg.en_cnt) : '0;
    state_next.io_cnt = (en_on & io_on) ? pwrseq_pkg::sat_inc(state_reg.io_cnt) : '0;

    case (state_reg.phase)
      pwrseq_pkg::DEV_OFF: begin
        if (en_on) begin
          state_next.phase = pwrseq_pkg::DEV_BOOT;
        end
      end

      pwrseq_pkg::DEV_BOOT: begin
        if (io_ok) begin
          state_next.phase = pwrseq_pkg::DEV_GPIO;
        end
      end

      pwrseq_pkg::DEV_GPIO: begin
        // GPIO has been live for at least one cycle when CTS turns ready.
        if (io_ok && state_reg.en_cnt > pwrseq_pkg::CNT_W'(CTS_MIN_CYC)) begin
          state_next.phase = pwrseq_pkg::DEV_READY;
        end
      end

      pwrseq_pkg::DEV_READY: begin
        // Held until the enable or the IO supply goes.
        state_next.phase = pwrseq_pkg::DEV_READY;
      end

      default: begin
        state_next.phase = pwrseq_pkg::DEV_OFF;
      end
    endcase

    // Losing the enable restarts the whole sequence; losing only the IO supply
    // restarts the IO settling wait, since the pins are no longer referenced.
    if (!en_on) begin
      state_next.phase = pwrseq_pkg::DEV_OFF;
    end else if (!io_on && state_reg.phase != pwrseq_pkg::DEV_OFF) begin
      state_next.phase = pwrseq_pkg::DEV_BOOT;
    end

    state_next.gpo_oe = (state_next.phase == pwrseq_pkg::DEV_GPIO) ||
                        (state_next.phase == pwrseq_pkg::DEV_READY);
    state_next.cts_ready = (state_next.phase == pwrseq_pkg::DEV_READY);

    state_next.gpo_val = state_next.gpo_oe ? gpo_value : '0;
    // Inputs read zero while GPIO is inactive.
    state_next.gpi_value = state_reg.gpo_oe ? state_reg.gpi_sync : '0;

    // Losing readiness aborts a frame and parks the line idle high.
    state_next.tx = pwrseq_pkg::tx_step(state_reg.tx, state_reg.cts_ready, tx_load, tx_data, div);
    state_next.rx = pwrseq_pkg::rx_step(state_reg.rx, state_reg.cts_ready, state_reg.txd_sync[1], div);
  end

  // The whole state is one register, reset as a unit.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= STATE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // A low level on the CTS line lets the host transmit.
  assign link.clear_to_send_out_n = ~state_reg.cts_ready;
  assign link.receive_data_out_n = state_reg.tx.line;
  assign link.gpo_val = state_reg.gpo_val;
  assign link.gpo_oe = state_reg.gpo_oe;

  assign rx_valid = state_reg.rx.done;
  assign rx_data = state_reg.rx.data;
  assign rx_frame_error = state_reg.rx.err;
  assign gpi_value = state_reg.gpi_value;
  assign service_mode = ~state_reg.svc_sync[1];
  assign ready = state_reg.cts_ready;

endmodule
`default_nettype wire

// File: hdl/host_sequencer.sv
// Host controller end: supply and enable sequencing, CTS watchdog and UART1.
`timescale 1ns/10ps
`default_nettype none
module host_sequencer #(
  parameter int unsigned GAP_CYC = pwrseq_pkg::GAP_CYC,
  parameter int unsigned CTS_MAX_CYC = pwrseq_pkg::CTS_MAX_CYC,
  parameter int unsigned EN_LOW_CYC = pwrseq_pkg::EN_LOW_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  module_link_if.host_side link,
  input wire logic power_request,
  input wire logic service_request,
  input wire logic [pwrseq_pkg::DIV_W-1:0] baud_div,
  input wire logic [pwrseq_pkg::GPI_W-1:0] gpi_value,
  input wire logic tx_valid,
  input wire logic [pwrseq_pkg::DATA_W-1:0] tx_data,
  output logic tx_ready,
  output logic rx_valid,
  output logic [pwrseq_pkg::DATA_W-1:0] rx_data,
  output logic rx_frame_error,
  output logic [pwrseq_pkg::GPO_W-1:0] gpo_seen,
  output logic link_ready,
  output logic startup_fault,
  output logic powered_off
);

  typedef struct packed {
    pwrseq_pkg::host_phase_type phase;
    logic [1:0] cts_sync;
    logic [1:0] rxd_sync;
    logic [pwrseq_pkg::GPO_W-1:0] gpo_meta;
    logic [pwrseq_pkg::GPO_W-1:0] gpo_sync;
    logic [pwrseq_pkg::CNT_W-1:0] cnt;
    logic vcc_in;
    logic enable;
    logic vcc_io;
    logic pins_up;
    logic rts_n;
    logic svc_n;
    logic [pwrseq_pkg::GPI_W-1:0] gpi;
    pwrseq_pkg::uart_tx_type tx;
    pwrseq_pkg::uart_rx_type rx;
  } host_state_type;

  localparam host_state_type STATE_RESET = '{
    phase: pwrseq_pkg::H_OFF, cts_sync: '1, rxd_sync: '1, gpo_meta: '0, gpo_sync: '0, cnt: '0,
    vcc_in: 1'h0, enable: 1'h0, vcc_io: 1'h0, pins_up: 1'h0, rts_n: 1'h0, svc_n: 1'h0, gpi: '0,
    tx: pwrseq_pkg::TX_RESET, rx: pwrseq_pkg::RX_RESET
  };

  host_state_type state_reg;
  host_state_type state_next;
  logic [pwrseq_pkg::DIV_W-1:0] div;
  logic running;

  assign running = (state_reg.phase == pwrseq_pkg::H_RUN);
  assign div = pwrseq_pkg::baud_select(service_request, baud_div);
  // Traffic starts only once the module has shown CTS ready.
  assign tx_ready = running & ~state_reg.cts_sync[1] & ~state_reg.tx.busy;

  always_comb begin
    state_next = state_reg;
    state_next.cts_sync = {state_reg.cts_sync[0], link.clear_to_send_out_n};
    state_next.rxd_sync = {state_reg.rxd_sync[0], link.receive_data_out_n};
    state_next.gpo_meta = link.gpo_oe ? link.gpo_val : '0;
    state_next.gpo_sync = state_reg.gpo_meta;
    state_next.cnt = pwrseq_pkg::sat_inc(state_reg.cnt);

    case (state_reg.phase)
      pwrseq_pkg::H_OFF: begin
        if (power_request) begin
          state_next.phase = pwrseq_pkg::H_MAIN;
          state_next.vcc_in = 1'h1;
          state_next.cnt = '0;
        end
      end
      pwrseq_pkg::H_MAIN: begin
        if (state_reg.cnt > pwrseq_pkg::CNT_W'(GAP_CYC)) begin
          state_next.phase = pwrseq_pkg::H_ENA;
          state_next.enable = 1'h1;
          state_next.cnt = '0;
        end
      end
      pwrseq_pkg::H_ENA: begin
        // The count keeps running so that the CTS window is timed from the enable.
        if (state_reg.cnt > pwrseq_pkg::CNT_W'(GAP_CYC)) begin
          state_next.phase = pwrseq_pkg::H_WAIT_CTS;
          state_next.vcc_io = 1'h1;
          state_next.pins_up = 1'h1;
        end
      end
      pwrseq_pkg::H_WAIT_CTS: begin
        if (!state_reg.cts_sync[1]) begin
          state_next.phase = pwrseq_pkg::H_RUN;
        end else if (state_reg.cnt > pwrseq_pkg::CNT_W'(CTS_MAX_CYC)) begin
          state_next.phase = pwrseq_pkg::H_FAULT;
        end
      end
      pwrseq_pkg::H_RUN, pwrseq_pkg::H_FAULT: begin
        state_next.phase = state_reg.phase;
      end
      pwrseq_pkg::H_DISABLE: begin
        if (state_reg.cnt > pwrseq_pkg::CNT_W'(EN_LOW_CYC)) begin
          state_next.phase = pwrseq_pkg::H_PINS_LOW;
          state_next.pins_up = 1'h0;
        end
      end
      pwrseq_pkg::H_PINS_LOW: begin
        state_next.phase = pwrseq_pkg::H_IO_OFF;
        state_next.vcc_io = 1'h0;
      end
      pwrseq_pkg::H_IO_OFF: begin
        state_next.phase = pwrseq_pkg::H_OFF;
        state_next.vcc_in = 1'h0;
      end
      default: begin
        state_next = STATE_RESET;
      end
    endcase

    // A dropped request during start-up or run always takes the full shutdown path.
    if (!power_request && (state_reg.phase == pwrseq_pkg::H_MAIN || state_reg.phase == pwrseq_pkg::H_ENA ||
        state_reg.phase == pwrseq_pkg::H_WAIT_CTS || running || state_reg.phase == pwrseq_pkg::H_FAULT)) begin
      state_next.phase = pwrseq_pkg::H_DISABLE;
      state_next.enable = 1'h0;
      state_next.cnt = '0;
    end

    state_next.rts_n = state_next.pins_up & (state_next.phase != pwrseq_pkg::H_RUN);
    state_next.svc_n = state_next.pins_up & ~service_request;
    state_next.gpi = state_next.pins_up ? gpi_value : '0;
    state_next.tx = pwrseq_pkg::tx_step(state_reg.tx, running, tx_ready & tx_valid, tx_data, div);
    state_next.rx = pwrseq_pkg::rx_step(state_reg.rx, running, state_reg.rxd_sync[1], div);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= STATE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // All module inputs are driven at all times; all but the supplies and enable are low whenever the pins are down.
  assign link.vcc_in = state_reg.vcc_in;
  assign link.module_enable = state_reg.enable;
  assign link.vcc_io = state_reg.vcc_io;
  assign link.request_to_send_in_n_drv = state_reg.rts_n;
  assign link.request_to_send_in_n_oe = 1'h1;
  assign link.transmit_data_in_n_drv = state_reg.pins_up & state_reg.tx.line;
  assign link.transmit_data_in_n_oe = 1'h1;
  assign link.service_n_drv = state_reg.svc_n;
  assign link.service_n_oe = 1'h1;
  assign link.gpi_drv = state_reg.gpi;
  assign link.gpi_oe = 1'h1;

  assign rx_valid = state_reg.rx.done;
  assign rx_data = state_reg.rx.data;
  assign rx_frame_error = state_reg.rx.err;
  assign gpo_seen = state_reg.gpo_sync;
  assign link_ready = running;
  assign startup_fault = (state_reg.phase == pwrseq_pkg::H_FAULT);
  assign powered_off = (state_reg.phase == pwrseq_pkg::H_OFF);

endmodule
`default_nettype wire

// File: dv/pwrseq_props.sv
// Timing checker for the host to module power and UART link.
`timescale 1ns/10ps
`default_nettype none
module pwrseq_props #(
  parameter int unsigned GAP_CYC = 20,
  parameter int unsigned CTS_MIN_CYC = 200,
  parameter int unsigned CTS_MAX_CYC = 1000,
  parameter int unsigned EN_LOW_CYC = 50
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic vcc_in,
  input wire logic module_enable,
  input wire logic vcc_io,
  input wire logic clear_to_send_out_n,
  input wire logic receive_data_out_n,
  input wire logic transmit_data_in_n_drv,
  input wire logic [pwrseq_pkg::GPI_W-1:0] gpi_drv,
  input wire logic gpo_oe
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // Level-age counters; the run is short enough that they never wrap.
  logic [31:0] vin_reg;
  logic [31:0] ena_reg;
  logic [31:0] io_reg;
  logic [31:0] off_reg;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      vin_reg <= 32'h0000_0000;
      ena_reg <= 32'h0000_0000;
      io_reg <= 32'h0000_0000;
      off_reg <= 32'h0000_0000;
    end else begin
      vin_reg <= vcc_in ? vin_reg + 32'h0000_0001 : 32'h0000_0000;
      ena_reg <= module_enable ? ena_reg + 32'h0000_0001 : 32'h0000_0000;
      io_reg <= vcc_io ? io_reg + 32'h0000_0001 : 32'h0000_0000;
      off_reg <= module_enable ? 32'h0000_0000 : off_reg + 32'h0000_0001;
    end
  end
  property p_ena_gap; $rose(module_enable) |-> vin_reg > GAP_CYC; endproperty
  a_ena_gap: assert property (p_ena_gap) else $error("enable raised too soon after main supply");
  property p_io_gap; $rose(vcc_io) |-> ena_reg > GAP_CYC; endproperty
  a_io_gap: assert property (p_io_gap) else $error("IO supply raised too soon after enable");
  property p_cts_window; $fell(clear_to_send_out_n) |-> ena_reg > CTS_MIN_CYC && ena_reg < CTS_MAX_CYC; endproperty
  a_cts_window: assert property (p_cts_window) else $error("clear to send outside its window");
  property p_cts_io; !clear_to_send_out_n |-> io_reg > GAP_CYC; endproperty
  a_cts_io: assert property (p_cts_io) else $error("clear to send before IO supply settled");
  property p_gpo_io; gpo_oe |-> io_reg > GAP_CYC; endproperty
  a_gpo_io: assert property (p_gpo_io) else $error("general outputs driven before IO supply settled");
  property p_gpo_first; $fell(clear_to_send_out_n) |-> gpo_oe && $past(gpo_oe); endproperty
  a_gpo_first: assert property (p_gpo_first) else $error("clear to send before general outputs");
  property p_pins_late; $fell(transmit_data_in_n_drv) && !module_enable |-> off_reg > EN_LOW_CYC; endproperty
  a_pins_late: assert property (p_pins_late) else $error("input pins lowered too soon");
  property p_gpi_low; $fell(vcc_io) |-> gpi_drv == '0 && !transmit_data_in_n_drv; endproperty
  a_gpi_low: assert property (p_gpi_low) else $error("IO supply removed with lines high");
  property p_io_first; $fell(vcc_in) |-> !vcc_io; endproperty
  a_io_first: assert property (p_io_first) else $error("main supply removed before IO supply");
  property p_rxd_cts; $fell(receive_data_out_n) |-> !clear_to_send_out_n; endproperty
  a_rxd_cts: assert property (p_rxd_cts) else $error("module sent while not ready");
  c_cts: cover property ($fell(clear_to_send_out_n));
  c_frame: cover property ($fell(receive_data_out_n));
  c_off: cover property ($fell(vcc_in));
endmodule
`default_nettype wire

// File: dv/module_power_enable_sequencer_bench.sv
// Self-checking bench for the host sequencer and module end joined by their link.
`timescale 1ns/10ps
`default_nettype none
module module_power_enable_sequencer_bench;
  localparam int unsigned GAP = 20;
  localparam int unsigned CTS_MIN = 200;
  localparam int unsigned CTS_MAX = 1000;
  localparam int unsigned EN_LOW = 50;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic power_request = 1'b0;
  logic service_request = 1'b0;
  logic [15:0] baud_div = 16'h0008;
  logic [2:0] h_gpi = 3'h5;
  logic [4:0] gpo_value = 5'h13;
  logic h_tx_valid = 1'b0;
  logic m_tx_valid = 1'b0;
  logic [7:0] h_tx_data = 8'h00;
  logic [7:0] m_tx_data = 8'h00;
  logic h_tx_ready, h_rx_valid, h_rx_err, link_ready, startup_fault, powered_off;
  logic m_tx_ready, m_rx_valid, m_rx_err, service_mode, m_ready;
  logic [7:0] h_rx_data, m_rx_data;
  logic [4:0] gpo_seen;
  logic [2:0] m_gpi;
  int n_errors = 0;
  int checks = 0;
  int cyc = 0;
  int t_ena, t_cts, t_ena_off, t_io_off, t_in_off, t_gpi_off;
  module_link_if u_module_link_if ();
  module_end #(.GAP_CYC(GAP), .CTS_MIN_CYC(CTS_MIN)) u_module_end (.mclk(mclk), .rst_n(rst_n),
    .link(u_module_link_if), .baud_div(baud_div), .tx_valid(m_tx_valid), .tx_data(m_tx_data),
    .tx_ready(m_tx_ready), .rx_valid(m_rx_valid), .rx_data(m_rx_data), .rx_frame_error(m_rx_err),
    .gpo_value(gpo_value), .gpi_value(m_gpi), .service_mode(service_mode), .ready(m_ready));
  host_sequencer #(.GAP_CYC(GAP), .CTS_MAX_CYC(CTS_MAX), .EN_LOW_CYC(EN_LOW)) u_host_sequencer (.mclk(mclk),
    .rst_n(rst_n), .link(u_module_link_if), .power_request(power_request), .service_request(service_request),
    .baud_div(baud_div), .gpi_value(h_gpi), .tx_valid(h_tx_valid), .tx_data(h_tx_data), .tx_ready(h_tx_ready),
    .rx_valid(h_rx_valid), .rx_data(h_rx_data), .rx_frame_error(h_rx_err), .gpo_seen(gpo_seen),
    .link_ready(link_ready), .startup_fault(startup_fault), .powered_off(powered_off));
  pwrseq_props #(.GAP_CYC(GAP), .CTS_MIN_CYC(CTS_MIN), .CTS_MAX_CYC(CTS_MAX), .EN_LOW_CYC(EN_LOW)) u_props (
    .mclk(mclk), .rst_n(rst_n), .vcc_in(u_module_link_if.vcc_in), .module_enable(u_module_link_if.module_enable),
    .vcc_io(u_module_link_if.vcc_io), .clear_to_send_out_n(u_module_link_if.clear_to_send_out_n),
    .receive_data_out_n(u_module_link_if.receive_data_out_n),
    .transmit_data_in_n_drv(u_module_link_if.transmit_data_in_n_drv), .gpi_drv(u_module_link_if.gpi_drv),
    .gpo_oe(u_module_link_if.gpo_oe));
  always #2 mclk = ~mclk;
  always @(posedge u_module_link_if.module_enable) t_ena = cyc;
  always @(negedge u_module_link_if.clear_to_send_out_n) t_cts = cyc;
  always @(negedge u_module_link_if.module_enable) t_ena_off = cyc;
  always @(negedge u_module_link_if.vcc_io) t_io_off = cyc;
  always @(negedge u_module_link_if.vcc_in) t_in_off = cyc;
  always @(negedge u_module_link_if.gpi_drv[0]) t_gpi_off = cyc;
  task automatic conclude();
    if (n_errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic compare(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // The limit covers power-up, three fast frames, one service-rate frame and shutdown.
  // Counting on the falling edge keeps the time stamps clear of rising-edge updates.
  always @(negedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 75000) begin
      n_errors++;
      conclude();
    end
  end
  task automatic xfer(input logic to_module, input logic [7:0] b);
    @(posedge mclk);
    h_tx_valid <= to_module;
    m_tx_valid <= !to_module;
    h_tx_data <= b;
    m_tx_data <= b;
    @(negedge mclk);
    while ((to_module ? h_tx_ready : m_tx_ready) !== 1'b1) @(negedge mclk);
    @(posedge mclk);
    h_tx_valid <= 1'b0;
    m_tx_valid <= 1'b0;
    @(negedge mclk);
    while ((to_module ? m_rx_valid : h_rx_valid) !== 1'b1) @(negedge mclk);
    compare("rx_data", 32'(b), 32'(to_module ? m_rx_data : h_rx_data));
    compare("rx_frame_error", 32'h0000_0000, 32'(to_module ? m_rx_err : h_rx_err));
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    compare("cts_n in reset", 32'h0000_0001, 32'(u_module_link_if.clear_to_send_out_n));
    compare("powered_off in reset", 32'h0000_0001, 32'(powered_off));
    rst_n <= 1'b1;
    @(posedge mclk);
    power_request <= 1'b1;
    @(negedge mclk);
    while (link_ready !== 1'b1) @(negedge mclk);
    compare("cts window", 32'h0000_0001, 32'(t_cts - t_ena > CTS_MIN && t_cts - t_ena < CTS_MAX));
    compare("module ready", 32'h0000_0001, 32'(m_ready));
    compare("gpo_seen", 32'(gpo_value), 32'(gpo_seen));
    compare("module gpi", 32'(h_gpi), 32'(m_gpi));
    compare("startup_fault", 32'h0000_0000, 32'(startup_fault));
    xfer(1'b1, 8'h5a);
    xfer(1'b1, 8'h81);
    xfer(1'b0, 8'ha5);
    @(posedge mclk);
    service_request <= 1'b1;
    repeat (8) @(negedge mclk);
    compare("service_mode on", 32'h0000_0001, 32'(service_mode));
    xfer(1'b1, 8'h3c);
    @(posedge mclk);
    service_request <= 1'b0;
    repeat (8) @(negedge mclk);
    compare("service_mode off", 32'h0000_0000, 32'(service_mode));
    @(posedge mclk);
    power_request <= 1'b0;
    while (powered_off !== 1'b1) @(negedge mclk);
    compare("disable to io off", 32'h0000_0001, 32'(t_io_off - t_ena_off > EN_LOW));
    compare("pins low after disable", 32'h0000_0001, 32'(t_gpi_off - t_ena_off > EN_LOW));
    compare("pins before io off", 32'h0000_0001, 32'(t_io_off > t_gpi_off));
    compare("io before main off", 32'h0000_0001, 32'(t_in_off > t_io_off));
    compare("gpo_oe off", 32'h0000_0000, 32'(u_module_link_if.gpo_oe));
    compare("cts_n off", 32'h0000_0001, 32'(u_module_link_if.clear_to_send_out_n));
    conclude();
  end
endmodule
`default_nettype wire
